/* File: hw/flash_erase_pkg.sv */
// Purpose: Shared constants and types for the whole-array erase control block.
// Assumes: Block clock of 10 MHz; four sectors; lock level given by two pins.
// Notes: Instruction codes and status layout are held here once.
package flash_erase_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Instruction codes.
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_CHIP_ERASE = 8'h62;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: the erase time is given in milliseconds and converted to cycles.
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int ERASE_TIME_MS = 3500;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * (CLK_FREQ_HZ / 1000);
   localparam int TIMER_W = 26;

   ////////////////////////////////////////////////////////////////////////////
   // Status byte field positions and reset values.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEN_BIT = 1;
   localparam int STAT_LOCK_LO_BIT = 2;
   localparam int STAT_LOCK_HI_BIT = 3;
   localparam int NUM_SECTORS = 4;
   localparam logic WEN_RESET = 1'b0;
   localparam logic SO_RESET = 1'b0;
   localparam logic [4:0] SYNC_RESET = 5'h10;
   localparam logic [2:0] BIT_CNT_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // State encodings.
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_ERASE = 2'b10
   } seq_state_t;

   typedef enum logic [4:0] {
      FR_IDLE = 5'b00001,
      FR_OPCODE = 5'b00010,
      FR_HELD = 5'b00100,
      FR_STATUS = 5'b01000,
      FR_SKIP = 5'b10000
   } frame_state_t;

   // Sectors locked out by a protection level; sector 3 is the top bit.
   function automatic logic [NUM_SECTORS-1:0] lock_mask(input logic [1:0] level);
      logic [NUM_SECTORS-1:0] m;
      m = 4'h0;
      unique case (level)
         2'h0: m = 4'h0;
         2'h1: m = 4'h8;
         2'h2: m = 4'hC;
         2'h3: m = 4'hF;
      endcase
      return m;
   endfunction : lock_mask

endpackage : flash_erase_pkg

/* File: hw/erase_if.sv */
// Purpose: Carries the erase request and progress between control and sequencer.
// Assumes: Both ends share one clock.
// Notes: Start is a one-cycle pulse; done is a one-cycle pulse.
`timescale 1ns/100ps
interface erase_if;
   import flash_erase_pkg::*;
   logic start;
   logic [NUM_SECTORS-1:0] mask;
   logic busy;
   logic done;
   logic [NUM_SECTORS-1:0] sectors;

   modport ctl (output start, output mask, input busy, input done, input sectors);
   modport seq (input start, input mask, output busy, output done, output sectors);
endinterface : erase_if

/* File: hw/erase_sequencer.sv */
// Purpose: Self-timed whole-array erase cycle with a sector select output.
// Assumes: Start only arrives while idle.
// Notes: The cycle length is a parameter so a simulation can shorten it.
`timescale 1ns/100ps
module erase_sequencer #(
   parameter int unsigned CYCLES = flash_erase_pkg::ERASE_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   erase_if.seq ers
);
   import flash_erase_pkg::*;

   localparam logic [TIMER_W-1:0] LAST = TIMER_W'(CYCLES - 1);

   seq_state_t state_ff, nxt_state;
   logic [TIMER_W-1:0] cnt_ff, nxt_cnt;
   logic [NUM_SECTORS-1:0] sect_ff, nxt_sect;
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;

   ////////////////////////////////////////////////////////////////////////////
   // The cycle runs on its own counter and needs nothing from the host.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_sect = sect_ff;
      nxt_done = 1'b0;
      unique case (state_ff)
         SEQ_IDLE: begin
            if (ers.start) begin
               nxt_state = SEQ_ERASE;
               nxt_cnt = '0;
               nxt_sect = ers.mask;
            end
         end
         SEQ_ERASE: begin
            if (cnt_ff == LAST) begin
               nxt_state = SEQ_IDLE;
               nxt_sect = '0;
               nxt_done = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
      endcase
      nxt_busy = (nxt_state == SEQ_ERASE);
   end

   // Registers of the sequencer.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_ff <= SEQ_IDLE;
         cnt_ff <= '0;
         sect_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         sect_ff <= nxt_sect;
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   assign ers.busy = busy_ff;
   assign ers.done = done_ff;
   assign ers.sectors = sect_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the erase cycle.
   a_mask_loaded: assert property (@(posedge clk_i) disable iff (srst_i)
      (ers.start && state_ff == SEQ_IDLE) |=> (ers.sectors == $past(ers.mask)) && ers.busy)
      else $error("Sector select does not match the accepted mask.");

   a_sectors_steady: assert property (@(posedge clk_i) disable iff (srst_i)
      (state_ff == SEQ_ERASE && $past(state_ff) == SEQ_ERASE) |-> $stable(sect_ff) && busy_ff)
      else $error("Sector select changed during the erase cycle.");

   a_done_count: assert property (@(posedge clk_i) disable iff (srst_i)
      ers.done |-> ($past(cnt_ff) == LAST) && !ers.busy && $past(busy_ff))
      else $error("Erase cycle ended at the wrong count.");

endmodule : erase_sequencer

/* File: hw/chip_erase_ctrl.sv */
// Purpose: Serial instruction front end that accepts and runs the whole-array erase.
// Assumes: Host uses SPI mode 0 or 3 with a clock far slower than clk_i.
// Notes: Chip select, serial clock, data and lock pins are all synchronised here.
`timescale 1ns/100ps

// Overview of operation
// - Erase all sectors not locked out.
// - Erase only when write enable set.
// - Erase runs alone to completion.
// - Erase stays busy about 3.5 seconds.
// - While busy, only status read answered.
// - Write enable cleared at erase end.
// - Status bit 0 shows busy.
// - Locked sectors never touched.
// - Unenabled erase ignored until deselect.
module chip_erase_ctrl #(
   parameter int unsigned ERASE_CYCLES_P = flash_erase_pkg::ERASE_CYCLES
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic lock_level_bit_low_i,
   input wire logic lock_level_bit_high_i,
   output logic so_o,
   output logic so_oe_n_o,
   output logic [flash_erase_pkg::NUM_SECTORS-1:0] sector_erase_o,
   output logic busy_o,
   output logic write_enable_o
);
   import flash_erase_pkg::*;

   erase_if ers ();

   logic [4:0] s1_ff;
   logic [4:0] s2_ff;
   logic [4:0] s3_ff;
   logic cs_n_s;
   logic cs_rise;
   logic sck_rise;
   logic sck_fall;
   logic si_s;
   logic [1:0] level_s;
   logic [7:0] status;
   logic [7:0] in_byte;

   frame_state_t frame_ff, nxt_frame;
   logic [2:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic [7:0] opcode_ff, nxt_opcode;
   logic [2:0] out_idx_ff, nxt_out_idx;
   logic so_ff, nxt_so;
   logic so_oe_n_ff, nxt_so_oe_n;
   logic wen_ff, nxt_wen;
   logic start_ff, nxt_start;
   logic [NUM_SECTORS-1:0] mask_ff, nxt_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the third stage only serves edge detection.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_ff <= SYNC_RESET;
         s2_ff <= SYNC_RESET;
         s3_ff <= SYNC_RESET;
      end else begin
         s1_ff <= {cs_n_i, sck_i, si_i, lock_level_bit_high_i, lock_level_bit_low_i};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Edge detection on the synchronised serial clock and select.
   assign cs_n_s = s2_ff[4];
   assign cs_rise = s2_ff[4] & ~s3_ff[4];
   assign sck_rise = ~cs_n_s & s2_ff[3] & ~s3_ff[3];
   assign sck_fall = ~cs_n_s & ~s2_ff[3] & s3_ff[3];
   assign si_s = s2_ff[2];
   assign level_s = s2_ff[1:0];
   assign in_byte = {shift_ff[6:0], si_s};

   // Status byte: busy, write enable and the lock level.
   always_comb begin
      status = 8'h00;
      status[STAT_BUSY_BIT] = ers.busy;
      status[STAT_WEN_BIT] = wen_ff;
      status[STAT_LOCK_LO_BIT] = level_s[0];
      status[STAT_LOCK_HI_BIT] = level_s[1];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame decode, instruction execution and write enable state.
   always_comb begin
      nxt_frame = frame_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift = shift_ff;
      nxt_opcode = opcode_ff;
      nxt_out_idx = out_idx_ff;
      nxt_so = so_ff;
      nxt_so_oe_n = so_oe_n_ff;
      nxt_wen = wen_ff;
      nxt_start = 1'b0;
      nxt_mask = mask_ff;
      if (cs_n_s) begin
         nxt_frame = FR_IDLE;
         nxt_bit_cnt = BIT_CNT_RESET;
         nxt_so_oe_n = 1'b1;
         // Only a whole opcode byte with no trailing bits is executed. The cycle in which the erase
         // ends still counts as busy, so the old write enable cannot start a second erase.
         if (cs_rise && frame_ff == FR_HELD && !ers.busy && !ers.done) begin
            unique case (opcode_ff)
               OP_WRITE_ENABLE: nxt_wen = 1'b1;
               OP_WRITE_DISABLE: nxt_wen = 1'b0;
               OP_CHIP_ERASE: begin
                  if (wen_ff) begin
                     nxt_start = 1'b1;
                     nxt_mask = ~lock_mask(level_s);
                  end
               end
               default: ;
            endcase
         end
      end else begin
         unique case (frame_ff)
            FR_IDLE: begin
               nxt_frame = FR_OPCODE;
               nxt_bit_cnt = BIT_CNT_RESET;
            end
            FR_OPCODE: begin
               if (sck_rise) begin
                  nxt_shift = in_byte;
                  nxt_bit_cnt = bit_cnt_ff + 1'b1;
                  if (bit_cnt_ff == 3'h7) begin
                     nxt_opcode = in_byte;
                     nxt_out_idx = 3'h0;
                     // Status read stays answered even while erasing.
                     nxt_frame = (in_byte == OP_STATUS_READ) ? FR_STATUS : FR_HELD;
                  end
               end
            end
            FR_HELD: begin
               if (sck_rise) begin
                  nxt_frame = FR_SKIP;
               end
            end
            FR_STATUS: begin
               // Most significant bit first, repeated for as long as the host clocks.
               if (sck_fall) begin
                  nxt_so = status[~out_idx_ff];
                  nxt_so_oe_n = 1'b0;
                  nxt_out_idx = out_idx_ff + 1'b1;
               end
            end
            FR_SKIP: ;
         endcase
      end
      // The end of the erase drops write enable; instructions are refused in that cycle as well.
      if (ers.done) begin
         nxt_wen = 1'b0;
      end
   end

   // Registers of the frame decoder.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         frame_ff <= FR_IDLE;
         bit_cnt_ff <= BIT_CNT_RESET;
         shift_ff <= 8'h00;
         opcode_ff <= 8'h00;
         out_idx_ff <= 3'h0;
         so_ff <= SO_RESET;
         so_oe_n_ff <= 1'b1;
         wen_ff <= WEN_RESET;
         start_ff <= 1'b0;
         mask_ff <= '0;
      end else begin
         frame_ff <= nxt_frame;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff <= nxt_shift;
         opcode_ff <= nxt_opcode;
         out_idx_ff <= nxt_out_idx;
         so_ff <= nxt_so;
         so_oe_n_ff <= nxt_so_oe_n;
         wen_ff <= nxt_wen;
         start_ff <= nxt_start;
         mask_ff <= nxt_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Erase sequencer and outputs.
   assign ers.start = start_ff;
   assign ers.mask = mask_ff;

   erase_sequencer #(
      .CYCLES(ERASE_CYCLES_P)
   ) u_seq (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ers(ers)
   );

   assign so_o = so_ff;
   assign so_oe_n_o = so_oe_n_ff;
   assign sector_erase_o = ers.sectors;
   assign busy_o = ers.busy;
   assign write_enable_o = wen_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on instruction acceptance.
   a_start_needs_wen: assert property (@(posedge clk_i) disable iff (srst_i)
      start_ff |-> wen_ff && !ers.busy && $past(opcode_ff) == OP_CHIP_ERASE)
      else $error("Erase started without write enable.");

   a_start_on_deselect: assert property (@(posedge clk_i) disable iff (srst_i)
      start_ff |-> $past(cs_rise) && $past(frame_ff) == FR_HELD)
      else $error("Erase started without a clean deselect.");

   a_busy_ignores: assert property (@(posedge clk_i) disable iff (srst_i)
      (ers.busy && cs_rise && !ers.done) |=> !start_ff && (wen_ff == $past(wen_ff)))
      else $error("Instruction acted on while erasing.");

   a_wen_clear_end: assert property (@(posedge clk_i) disable iff (srst_i)
      $fell(ers.busy) |=> !wen_ff [*2])
      else $error("Write enable kept after the erase.");

   a_status_busy_bit: assert property (@(posedge clk_i) disable iff (srst_i)
      (frame_ff == FR_STATUS && !cs_n_s && sck_fall && out_idx_ff == 3'h7) |=>
      (so_ff == $past(ers.busy)) && !so_oe_n_ff)
      else $error("Status bit 0 does not show busy.");

   a_no_wen_ignored: assert property (@(posedge clk_i) disable iff (srst_i)
      (cs_rise && frame_ff == FR_HELD && opcode_ff == OP_CHIP_ERASE && !wen_ff) |=> !start_ff ##1 !ers.busy)
      else $error("Erase accepted without write enable.");

   a_lock_respected: assert property (@(posedge clk_i) disable iff (srst_i)
      start_ff |-> ((mask_ff & lock_mask($past(level_s))) == '0) && (mask_ff | lock_mask($past(level_s))) == 4'hF)
      else $error("Erase mask covers a locked sector.");

endmodule : chip_erase_ctrl

/* File: testbench/spi_host_model.sv */
// Purpose: Behavioural SPI host that sends instruction frames in mode 0.
// Assumes: One serial clock half period is four block clocks (800 ns period).
// Notes: The serial clock stands low between frames; data in toggles when idle.
`timescale 1ns/100ps
module spi_host_model (
   input wire logic clk_i,
   input wire logic so_i,
   input wire logic so_oe_n_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o
);
   // Idle levels: deselected, clock low.
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // Waits n block clocks and lands just after the last edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick

   // Sends nbits of op MSB first, clocks rdbits of reply, deselects in clock low time.
   task automatic xfer(input logic [7:0] op, input int nbits, input int rdbits,
                       output logic [7:0] rd, output logic oe_n);
      rd = 8'h00;
      oe_n = 1'b0;
      tick(1);
      cs_n_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si_o = op[7 - (i % 8)];
         tick(4);
         sck_o = 1'b1;
         tick(4);
         sck_o = 1'b0;
      end
      for (int i = 0; i < rdbits; i++) begin
         tick(4);
         sck_o = 1'b1;
         rd = {rd[6:0], so_i};
         oe_n = oe_n | so_oe_n_i;
         tick(4);
         sck_o = 1'b0;
      end
      tick(4);
      cs_n_o = 1'b1;
      si_o = ~si_o;
      tick(4);
   endtask : xfer
endmodule : spi_host_model

/* File: testbench/spi_flash_chip_erase_control_test.sv */
// Purpose: Self-checking bench of the whole-array erase control block.
// Assumes: Erase length shortened by parameter; lock level driven on pins.
// Notes: A small integer model tracks write enable, busy and lock level.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
   $display("Error %s expected %h seen %h", nm, ex, got); miscompares++; end end
module spi_flash_chip_erase_control_test;
   import flash_erase_pkg::*;
   localparam int unsigned P = 400;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic lock_lo = 1'b0;
   logic lock_hi = 1'b0;
   logic cs_n, sck, si, so_o, so_oe_n_o, busy_o, write_enable_o, oe_n;
   logic [NUM_SECTORS-1:0] sector_erase_o;
   logic so_last = 1'b0;
   logic so_wire;
   logic [7:0] rd;
   logic [31:0] lfsr_q = 32'h5A50730C;
   int miscompares = 0;
   int samples_checked = 0;
   int run = 0;
   int m_wen = 0;
   int m_busy = 0;
   int m_lvl = 0;

   ////////////////////////////////////////////////////////////
   // Clock, busy length counter and the released data line.
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) if (busy_o === 1'b1) run++;
   always @(posedge clk_i) if (so_oe_n_o === 1'b0) so_last <= so_o;
   assign so_wire = (so_oe_n_o === 1'b0) ? so_o : ~so_last;

   chip_erase_ctrl #(.ERASE_CYCLES_P(P)) i_chip_erase_ctrl (.clk_i(clk_i), .srst_i(srst_i),
      .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .lock_level_bit_low_i(lock_lo),
      .lock_level_bit_high_i(lock_hi), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
      .sector_erase_o(sector_erase_o), .busy_o(busy_o), .write_enable_o(write_enable_o));
   spi_host_model i_spi_host_model (.clk_i(clk_i), .so_i(so_wire), .so_oe_n_i(so_oe_n_o),
      .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

   ////////////////////////////////////////////////////////////
   // Sectors that an erase at a lock level may touch.
   function automatic logic [3:0] sect_exp(input int lvl);
      return (lvl == 0) ? 4'hF : (lvl == 1) ? 4'h7 : (lvl == 2) ? 4'h3 : 4'h0;
   endfunction : sect_exp

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // Sends one instruction, updates the model, compares the outputs.
   task automatic cmd(input logic [7:0] op, input int nbits);
      i_spi_host_model.xfer(op, nbits, 0, rd, oe_n);
      if (m_busy == 0 && nbits == 8) begin
         if (op == OP_WRITE_ENABLE) m_wen = 1;
         if (op == OP_WRITE_DISABLE) m_wen = 0;
         if (op == OP_CHIP_ERASE && m_wen == 1) begin
            m_busy = 1;
            m_lvl = {lock_hi, lock_lo};
         end
      end
      i_spi_host_model.tick(4);
      `CHK("busy", m_busy[0], busy_o)
      `CHK("wen", m_wen[0], write_enable_o)
      `CHK("sectors", (m_busy != 0) ? sect_exp(m_lvl) : 4'h0, sector_erase_o)
   endtask : cmd

   // Reads the status byte and compares every bit.
   task automatic status;
      i_spi_host_model.xfer(OP_STATUS_READ, 8, 8, rd, oe_n);
      `CHK("status", {4'h0, lock_hi, lock_lo, m_wen[0], m_busy[0]}, rd)
      `CHK("so_oe_n", 1'b0, oe_n)
   endtask : status

   // Waits a bounded time for the erase to end, then checks its length and wen clear.
   task automatic wait_idle;
      for (int i = 0; i < P + 20 && busy_o !== 1'b0; i++) i_spi_host_model.tick(1);
      if (busy_o !== 1'b0) begin
         miscompares++;
         finish_test();
      end else begin
         `CHK("busy_len", P, run)
         `CHK("sectors_end", 4'h0, sector_erase_o)
         m_busy = 0;
         m_wen = 0;
         i_spi_host_model.tick(1);
         `CHK("wen_end", 1'b0, write_enable_o)
      end
   endtask : wait_idle

   // Picks a random opcode that is none of the known instructions.
   function automatic logic [7:0] odd_op;
      lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h000000C5 : 32'h0);
      if (lfsr_q[7:0] inside {OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_STATUS_READ, OP_CHIP_ERASE})
         return lfsr_q[7:0] ^ 8'h80;
      return lfsr_q[7:0];
   endfunction : odd_op

   ////////////////////////////////////////////////////////////
   // Main sequence: refusals first, then an erase at every lock level.
   initial begin
      repeat (16) @(posedge clk_i);
      #1 srst_i = 1'b0;
      `CHK("oe_rst", 1'b1, so_oe_n_o)
      i_spi_host_model.tick(3);
      cmd(OP_CHIP_ERASE, 8);
      status();
      cmd(OP_WRITE_ENABLE, 8);
      cmd(OP_CHIP_ERASE, 5);
      cmd(OP_CHIP_ERASE, 9);
      cmd(odd_op(), 8);
      cmd(OP_WRITE_DISABLE, 8);
      status();
      for (int lvl = 0; lvl < 4; lvl++) begin
         {lock_hi, lock_lo} = lvl[1:0];
         cmd(OP_WRITE_ENABLE, 8);
         status();
         run = 0;
         cmd(OP_CHIP_ERASE, 8);
         cmd(OP_WRITE_DISABLE, 8);
         cmd(odd_op(), 8);
         status();
         wait_idle();
         status();
      end
      finish_test();
   end
endmodule : spi_flash_chip_erase_control_test
